// [common/rap_pkg.sv]
/*
 * Shared constants of the remote alarm panel and its transfer switch end.
 * Assumes one free-running 25 MHz system clock on both ends.
 * All timing is kept in 1 ms ticks from a prescaler.
 */
package rap_pkg;
	// ==========================================================
	// clock and tick
	localparam int unsigned CLK_HZ   = 25_000_000;
	localparam int unsigned TICK_HZ  = 1000;
	localparam int unsigned TICK_CYC = CLK_HZ / TICK_HZ;

	// ==========================================================
	// times in milliseconds, as printed or chosen
	localparam int unsigned HOLD_MS      = 1000;
	localparam int unsigned BATT_MS      = 15000;
	localparam int unsigned TIMEOUT_MS   = 120000;
	localparam int unsigned CHIRP_PER_MS = 600000;
	localparam int unsigned FAST_MS      = 1000;
	localparam int unsigned SLOW_MS      = 2000;
	localparam int unsigned CHIRP_ON_MS  = 100;
	localparam int unsigned DEB_MS       = 20;

	// ==========================================================
	// the same times as tick counts
	localparam int unsigned HOLD_TK      = HOLD_MS * TICK_HZ / 1000;
	localparam int unsigned BATT_TK      = BATT_MS * TICK_HZ / 1000;
	localparam int unsigned TIMEOUT_TK   = TIMEOUT_MS * TICK_HZ / 1000;
	localparam int unsigned CHIRP_PER_TK = CHIRP_PER_MS * TICK_HZ / 1000;
	localparam int unsigned FAST_TK      = FAST_MS * TICK_HZ / 1000;
	localparam int unsigned SLOW_TK      = SLOW_MS * TICK_HZ / 1000;
	localparam int unsigned CHIRP_ON_TK  = CHIRP_ON_MS * TICK_HZ / 1000;
	localparam int unsigned DEB_TK       = DEB_MS * TICK_HZ / 1000;

	// ==========================================================
	// widths and chirp counts
	localparam int unsigned CW           = 20;
	localparam int unsigned PW           = 16;
	localparam logic [1:0]  FAULT_CHIRPS = 2'h3;
	localparam logic [1:0]  RUN_CHIRPS   = 2'h1;

	typedef enum logic [1:0] {
		RAP_IDLE,
		RAP_STARTING,
		RAP_RUNNING,
		RAP_STOPPING
	} rap_state_e;
endpackage

// [common/rap_link_if.sv]
/*
 * Cable between the alarm panel and the transfer switch accessory board.
 * Assumes both ends sample what they receive through their own synchronisers.
 */
interface rap_link_if;
	logic test_contact;
	logic load_on_gen;
	logic gen_running;
	logic silent_mode;
	logic sys_fault;

	modport panel (
		output test_contact,
		input  load_on_gen,
		input  gen_running,
		input  silent_mode,
		input  sys_fault
	);
	modport xfer (
		input  test_contact,
		output load_on_gen,
		output gen_running,
		output silent_mode,
		output sys_fault
	);
endinterface

// [core/rap_xfer.sv]
/*
 * Transfer switch end of the panel link: turns the remote test contact into a
 * generator start request and reports source status back to the panel.
 * Assumes status inputs come from controller logic on sys_clk_i.
 */
module rap_xfer #(
	parameter int unsigned TICK_CYC = rap_pkg::TICK_CYC,
	parameter int unsigned HOLD_TK  = rap_pkg::HOLD_TK
) (
	// clock, reset, enable
	input  wire logic sys_clk_i,
	input  wire logic rst_b_i,
	input  wire logic ce_i,
	// controller status
	input  wire logic utility_avail_i,
	input  wire logic gen_running_i,
	input  wire logic load_on_gen_i,
	input  wire logic silent_mode_i,
	input  wire logic sys_fault_i,
	// selector switch 3: high selects maintained test input
	input  wire logic maintained_i,
	// to controller
	output logic      gen_start_o,
	// panel side
	rap_link_if.xfer  link
);
	// ==========================================================
	// parameter checks
	if (TICK_CYC < 2 || TICK_CYC > (1 << rap_pkg::PW)) begin : g_chk_tick
		$error("rap_xfer: TICK_CYC out of range");
	end
	if (HOLD_TK < 1 || HOLD_TK >= (1 << rap_pkg::CW)) begin : g_chk_hold
		$error("rap_xfer: HOLD_TK out of range");
	end

	// ==========================================================
	// synchronisers: contact and selector switch come from pins
	logic [1:0]               s1_r;
	logic [1:0]               s2_r;
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s1_r <= 2'h0;
			s2_r <= 2'h0;
		end else if (ce_i) begin
			s1_r <= {maintained_i, link.test_contact};
			s2_r <= s1_r;
		end
	end

	// ==========================================================
	// test control
	logic [rap_pkg::PW-1:0]   presc_r, presc_nxt;
	logic [rap_pkg::CW-1:0]   hold_r, hold_nxt;
	logic                     held_r, held_nxt;
	logic                     act_r, act_nxt;
	logic                     tick;
	logic                     contact;

	always_comb begin
		contact   = s2_r[0];
		tick      = (presc_r == rap_pkg::PW'(TICK_CYC - 1));
		presc_nxt = tick ? '0 : presc_r + 1'b1;
		hold_nxt  = hold_r;
		held_nxt  = held_r;
		act_nxt   = act_r;
		if (s2_r[1]) begin
			if (contact) begin
				act_nxt = 1'b1;
			end else if (utility_avail_i) begin
				act_nxt = 1'b0;
			end
			hold_nxt = '0;
			held_nxt = 1'b0;
		end else if (contact) begin
			// momentary input: a hold of the set time counts as one press
			if (tick && !held_r) begin
				if (hold_r == rap_pkg::CW'(HOLD_TK - 1)) begin
					held_nxt = 1'b1;
				end else begin
					hold_nxt = hold_r + 1'b1;
				end
			end
		end else begin
			hold_nxt = '0;
			held_nxt = 1'b0;
			if (held_r && (!act_r || utility_avail_i)) begin
				act_nxt = !act_r;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			presc_r           <= '0;
			hold_r            <= '0;
			held_r            <= 1'b0;
			act_r             <= 1'b0;
			gen_start_o       <= 1'b0;
			link.load_on_gen  <= 1'b0;
			link.gen_running  <= 1'b0;
			link.silent_mode  <= 1'b0;
			link.sys_fault    <= 1'b0;
		end else if (ce_i) begin
			presc_r           <= presc_nxt;
			hold_r            <= hold_nxt;
			held_r            <= held_nxt;
			act_r             <= act_nxt;
			gen_start_o       <= act_nxt;
			link.load_on_gen  <= load_on_gen_i;
			link.gen_running  <= gen_running_i;
			link.silent_mode  <= silent_mode_i;
			link.sys_fault    <= sys_fault_i;
		end
	end
endmodule

// [core/rap_panel.sv]
/*
 * Remote alarm panel: test and silence push buttons, source-running lamp,
 * fault lamp and chirp alarm.
 * Assumes the transfer switch end runs its test input in maintained mode and
 * that every button and status pin is asynchronous to sys_clk_i.
 */
// Notes on behaviour
// - one-second test hold requests start, flashes lamp
// - with no source, hold request until battery dies
// - second hold requests retransfer and generator stop
// - switch ignores stop while utility is absent
// - panel-started run: steady lamp, chirp per ten minutes
// - silence button toggles alarm mute
// - silence button lights every lamp
// - automatic or exercise run: steady lamp, silent
// - silent mode: lamp flashes fast, every second
// - starting or stopping: lamp flashes every two seconds
// - fault or low battery: steady lamp, three chirps
// - no start within two minutes flashes fault
// - switch test input set to maintained mode
// - closed contact runs test, open contact stops
module rap_panel #(
	parameter int unsigned TICK_CYC     = rap_pkg::TICK_CYC,
	parameter int unsigned HOLD_TK      = rap_pkg::HOLD_TK,
	parameter int unsigned BATT_TK      = rap_pkg::BATT_TK,
	parameter int unsigned TIMEOUT_TK   = rap_pkg::TIMEOUT_TK,
	parameter int unsigned CHIRP_PER_TK = rap_pkg::CHIRP_PER_TK,
	parameter int unsigned FAST_TK      = rap_pkg::FAST_TK,
	parameter int unsigned SLOW_TK      = rap_pkg::SLOW_TK,
	parameter int unsigned CHIRP_ON_TK  = rap_pkg::CHIRP_ON_TK,
	parameter int unsigned DEB_TK       = rap_pkg::DEB_TK
) (
	// clock, reset, enable
	input  wire logic sys_clk_i,
	input  wire logic rst_b_i,
	input  wire logic ce_i,
	// push buttons, high while pressed
	input  wire logic test_btn_i,
	input  wire logic silence_btn_i,
	// panel supply status
	input  wire logic batt_low_i,
	input  wire logic no_source_i,
	// annunciators
	output logic      run_lamp_o,
	output logic      fault_lamp_o,
	output logic      chirp_o,
	// transfer switch side
	rap_link_if.panel link
);
	// ==========================================================
	// parameter checks
	if (SLOW_TK != 2 * FAST_TK || FAST_TK < 2) begin : g_chk_blink
		$error("rap_panel: slow blink must be twice fast blink");
	end
	if (CHIRP_PER_TK >= (1 << rap_pkg::CW) || TIMEOUT_TK >= (1 << rap_pkg::CW)
		|| BATT_TK >= (1 << rap_pkg::CW) || 8 * CHIRP_ON_TK > CHIRP_PER_TK
		|| HOLD_TK < 1 || CHIRP_ON_TK < 1 || DEB_TK < 1 || DEB_TK > 255
		|| HOLD_TK >= (1 << rap_pkg::CW) || TICK_CYC < 2 || TICK_CYC > (1 << rap_pkg::PW))
	begin : g_chk_cnt
		$error("rap_panel: parameter out of range");
	end

	// ==========================================================
	// synchronisers and tick
	// bits: 7 no_source, 6 batt_low, 5 silence, 4 test, 3 fault,
	// 2 silent mode, 1 gen running, 0 load on gen
	logic [7:0]               s1_r;
	logic [7:0]               s2_r;
	logic [rap_pkg::PW-1:0]   presc_r;
	logic                     tick;

	assign tick = (presc_r == rap_pkg::PW'(TICK_CYC - 1));
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			{s1_r, s2_r} <= 16'h0000;
			presc_r <= '0;
		end else if (ce_i) begin
			s1_r    <= {no_source_i, batt_low_i, silence_btn_i, test_btn_i,
				link.sys_fault, link.silent_mode, link.gen_running, link.load_on_gen};
			s2_r    <= s1_r;
			presc_r <= tick ? '0 : presc_r + 1'b1;
		end
	end

	// ==========================================================
	// button debounce: a level must hold for the set ticks to count
	logic [1:0]               btn_r;
	for (genvar gi = 0; gi < 2; gi++) begin : g_deb
		logic [7:0] cnt_r, cnt_nxt;
		logic       lvl_nxt;
		always_comb begin
			cnt_nxt = cnt_r;
			lvl_nxt = btn_r[gi];
			if (s2_r[4+gi] == btn_r[gi]) begin
				cnt_nxt = 8'h00;
			end else if (tick) begin
				if (cnt_r == 8'(DEB_TK - 1)) begin
					cnt_nxt = 8'h00;
					lvl_nxt = s2_r[4+gi];
				end else begin
					cnt_nxt = cnt_r + 8'h01;
				end
			end
		end
		always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				{cnt_r, btn_r[gi]} <= 9'h000;
			end else if (ce_i) begin
				cnt_r     <= cnt_nxt;
				btn_r[gi] <= lvl_nxt;
			end
		end
	end

	// ==========================================================
	// test sequence
	rap_pkg::rap_state_e      st_r, st_nxt;
	logic [rap_pkg::CW-1:0]   hold_r, hold_nxt;
	logic [rap_pkg::CW-1:0]   tmr_r, tmr_nxt;
	logic [rap_pkg::CW-1:0]   batt_r, batt_nxt;
	logic                     armed_r, armed_nxt, tmo_r, tmo_nxt, req_nxt, hold_done;
	always_comb begin
		st_nxt    = st_r;
		tmr_nxt   = tmr_r;
		batt_nxt  = batt_r;
		tmo_nxt   = tmo_r;
		req_nxt   = link.test_contact;
		hold_nxt  = !btn_r[0] ? '0 : (armed_r && tick) ? hold_r + 1'b1 : hold_r;
		armed_nxt = armed_r | !btn_r[0];
		// a hold fires once; the button must be released before the next one
		hold_done = armed_r && btn_r[0] && tick && hold_r == rap_pkg::CW'(HOLD_TK - 1);
		if (hold_done) begin
			armed_nxt = 1'b0;
			hold_nxt  = '0;
		end
		case (st_r)
			rap_pkg::RAP_IDLE: begin
				if (hold_done) begin
					st_nxt   = rap_pkg::RAP_STARTING;
					req_nxt  = 1'b1;
					tmr_nxt  = '0;
					batt_nxt = '0;
					tmo_nxt  = 1'b0;
				end
			end
			rap_pkg::RAP_STARTING: begin
				if (tick && !tmo_r) begin
					tmr_nxt = tmr_r + 1'b1;
					tmo_nxt = (tmr_r == rap_pkg::CW'(TIMEOUT_TK - 1));
				end
				if (tick && s2_r[7]) begin
					batt_nxt = batt_r + 1'b1;
				end
				if (hold_done) begin
					st_nxt  = rap_pkg::RAP_STOPPING;
					req_nxt = 1'b0;
					tmo_nxt = 1'b0;
				end else if (s2_r[1] && s2_r[0]) begin
					st_nxt  = rap_pkg::RAP_RUNNING;
					tmo_nxt = 1'b0;
				end else if (tick && s2_r[7] && batt_r == rap_pkg::CW'(BATT_TK - 1)) begin
					// panel battery spent: the request drops with it
					st_nxt  = rap_pkg::RAP_IDLE;
					req_nxt = 1'b0;
					tmo_nxt = 1'b0;
				end
			end
			rap_pkg::RAP_RUNNING: begin
				if (hold_done) begin
					st_nxt  = rap_pkg::RAP_STOPPING;
					req_nxt = 1'b0;
				end
			end
			rap_pkg::RAP_STOPPING: begin
				// may stay here while the switch refuses to stop without utility
				if (!s2_r[1]) begin
					st_nxt = rap_pkg::RAP_IDLE;
				end
			end
			default: begin
				st_nxt  = rap_pkg::RAP_IDLE;
				req_nxt = 1'b0;
			end
		endcase
	end
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_r              <= rap_pkg::RAP_IDLE;
			{hold_r, tmr_r, batt_r, armed_r, tmo_r, link.test_contact} <= '0;
		end else if (ce_i) begin
			st_r              <= st_nxt;
			hold_r            <= hold_nxt;
			tmr_r             <= tmr_nxt;
			batt_r            <= batt_nxt;
			armed_r           <= armed_nxt;
			tmo_r             <= tmo_nxt;
			link.test_contact <= req_nxt;
		end
	end

	// ==========================================================
	// lamps and chirps
	logic [rap_pkg::CW-1:0]   blink_r, blink_nxt;
	logic [rap_pkg::CW-1:0]   per_r, per_nxt;
	logic [rap_pkg::CW-1:0]   ph_r, ph_nxt;
	logic [1:0]               left_r, left_nxt;
	logic                     mute_r, mute_nxt, sil_prev_r, fprev_r;
	logic                     run_nxt, fault_nxt, chirp_nxt;
	logic                     slow_on, fast_on, fault_cond, run_cond;
	always_comb begin
		blink_nxt  = (blink_r == rap_pkg::CW'(SLOW_TK - 1)) ? '0 : blink_r + 1'b1;
		blink_nxt  = tick ? blink_nxt : blink_r;
		per_nxt    = per_r;
		ph_nxt     = ph_r;
		left_nxt   = left_r;
		mute_nxt   = mute_r ^ (btn_r[1] & !sil_prev_r);
		slow_on    = blink_r < rap_pkg::CW'(SLOW_TK / 2);
		fast_on    = (blink_r < rap_pkg::CW'(FAST_TK / 2))
			|| (blink_r >= rap_pkg::CW'(FAST_TK) && blink_r < rap_pkg::CW'(FAST_TK + FAST_TK / 2));
		fault_cond = s2_r[3] | s2_r[6];
		run_cond   = (st_r == rap_pkg::RAP_RUNNING) && s2_r[0];
		// a new fault restarts the period so its pattern sounds at once
		if (!(fault_cond || run_cond) || (fault_cond && !fprev_r)) begin
			per_nxt  = '0;
			left_nxt = (fault_cond || run_cond) ? left_r : 2'h0;
		end else if (tick) begin
			per_nxt = (per_r == rap_pkg::CW'(CHIRP_PER_TK - 1)) ? '0 : per_r + 1'b1;
			if (per_r == '0) begin
				left_nxt = fault_cond ? rap_pkg::FAULT_CHIRPS : rap_pkg::RUN_CHIRPS;
				ph_nxt   = '0;
			end else if (left_r != 2'h0) begin
				if (ph_r == rap_pkg::CW'(2 * CHIRP_ON_TK - 1)) begin
					ph_nxt   = '0;
					left_nxt = left_r - 2'h1;
				end else begin
					ph_nxt = ph_r + 1'b1;
				end
			end
		end
		chirp_nxt = (left_r != 2'h0) && (ph_r < rap_pkg::CW'(CHIRP_ON_TK)) && !mute_r;
		case (st_r)
			rap_pkg::RAP_STARTING, rap_pkg::RAP_STOPPING: run_nxt = slow_on;
			default: run_nxt = s2_r[0] && (s2_r[2] ? fast_on : 1'b1);
		endcase
		fault_nxt = fault_cond || (tmo_r && slow_on);
		if (btn_r[1]) begin
			run_nxt   = 1'b1;
			fault_nxt = 1'b1;
		end
	end
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			{blink_r, per_r, ph_r, left_r, mute_r, sil_prev_r, fprev_r} <= '0;
			{run_lamp_o, fault_lamp_o, chirp_o} <= 3'h0;
		end else if (ce_i) begin
			blink_r      <= blink_nxt;
			per_r        <= per_nxt;
			ph_r         <= ph_nxt;
			left_r       <= left_nxt;
			mute_r       <= mute_nxt;
			sil_prev_r   <= btn_r[1];
			fprev_r      <= fault_cond;
			run_lamp_o   <= run_nxt;
			fault_lamp_o <= fault_nxt;
			chirp_o      <= chirp_nxt;
		end
	end
endmodule

// [test/rap_assertions.sv]
/*
 * Checker for the panel link and the panel annunciators.
 * Assumes the bench timing: tick of 4 cycles, hold 5 ticks, slow blink 8 ticks.
 */
module rap_assertions (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// link
	input wire logic test_contact,
	input wire logic load_on_gen,
	input wire logic gen_running,
	input wire logic silent_mode,
	input wire logic sys_fault,
	// end ports
	input wire logic test_btn_i,
	input wire logic silence_btn_i,
	input wire logic batt_low_i,
	input wire logic utility_avail_i,
	input wire logic gen_start_o,
	input wire logic run_lamp_o,
	input wire logic fault_lamp_o,
	input wire logic chirp_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);

	// ==========================================================
	// run lengths, saturating so long waits never wrap
	logic [7:0] btn_r;
	logic [7:0] sil_r;
	logic [7:0] quiet_r;
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			btn_r   <= 8'h00;
			sil_r   <= 8'h00;
			quiet_r <= 8'h00;
		end else begin
			btn_r   <= !test_btn_i ? 8'h00 : (btn_r == 8'hFF) ? btn_r : btn_r + 8'h01;
			sil_r   <= !silence_btn_i ? 8'h00 : (sil_r == 8'hFF) ? sil_r : sil_r + 8'h01;
			quiet_r <= (test_contact || sys_fault || batt_low_i) ? 8'h00 :
				(quiet_r == 8'hFF) ? quiet_r : quiet_r + 8'h01;
		end
	end

	// ==========================================================
	// assertions
	a_hold_before_start: assert property ($rose(test_contact) |-> btn_r >= 8'h14)
		else $error("contact closed without a full hold");
	a_start_reaches_gen: assert property ($rose(test_contact) |-> ##[1:6] gen_start_o)
		else $error("start request not passed on");
	a_stop_refused: assert property (!utility_avail_i && gen_start_o |=> gen_start_o)
		else $error("generator stopped without utility");
	a_stop_reaches_gen: assert property (
		$fell(test_contact) && utility_avail_i |-> ##[1:6] !gen_start_o)
		else $error("stop request not passed on");
	a_start_blinks: assert property (
		$rose(test_contact) && !load_on_gen |-> ##[1:40] $fell(run_lamp_o))
		else $error("run lamp not blinking after start");
	a_lamp_test_on: assert property (sil_r >= 8'h18 |-> run_lamp_o && fault_lamp_o)
		else $error("lamp test not lighting lamps");
	a_fault_lamp_on: assert property (sys_fault [*5] |-> fault_lamp_o)
		else $error("fault lamp dark during fault");
	a_quiet_no_chirp: assert property (quiet_r >= 8'h40 |-> !chirp_o)
		else $error("chirp without test run or fault");

	cover property ($rose(chirp_o) && sys_fault);
	cover property (gen_running && load_on_gen && silent_mode);
	cover property ($fell(gen_start_o));
endmodule

// [test/testbench.sv]
/*
 * Bench joining the panel and the transfer switch end through the link.
 * Assumes shortened timing: tick 4 cycles, so slow blink 32, fast 16, chirp period 800.
 */
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	logic sys_clk_i, rst_b_i, ce_i, test_btn_i, silence_btn_i, batt_low_i, no_source_i;
	logic utility_avail_i, gen_running_i, load_on_gen_i, silent_mode_i, sys_fault_i;
	logic run_lamp_o, fault_lamp_o, chirp_o, gen_start_o;
	int   n_errors;
	int   checks;

	// shortened timing so every pattern fits in a short run
	localparam int unsigned TB_TICK = 4;
	localparam int unsigned TB_HOLD = 5;
	localparam int unsigned TB_BATT = 40;
	localparam int unsigned TB_TMO  = 60;
	localparam int unsigned TB_CPER = 200;
	localparam int unsigned TB_FAST = 4;
	localparam int unsigned TB_SLOW = 8;
	localparam int unsigned TB_CHON = 2;
	localparam int unsigned TB_DEB  = 2;

	rap_link_if lk ();

	rap_panel #(.TICK_CYC(TB_TICK), .HOLD_TK(TB_HOLD), .BATT_TK(TB_BATT), .TIMEOUT_TK(TB_TMO),
		.CHIRP_PER_TK(TB_CPER), .FAST_TK(TB_FAST), .SLOW_TK(TB_SLOW), .CHIRP_ON_TK(TB_CHON),
		.DEB_TK(TB_DEB))
	i_rap_panel (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
		.test_btn_i(test_btn_i), .silence_btn_i(silence_btn_i), .batt_low_i(batt_low_i),
		.no_source_i(no_source_i), .run_lamp_o(run_lamp_o), .fault_lamp_o(fault_lamp_o),
		.chirp_o(chirp_o), .link(lk.panel));

	// maintained mode tied on: the panel needs it
	rap_xfer #(.TICK_CYC(TB_TICK), .HOLD_TK(TB_HOLD)) i_rap_xfer (.sys_clk_i(sys_clk_i),
		.rst_b_i(rst_b_i), .ce_i(ce_i), .utility_avail_i(utility_avail_i),
		.gen_running_i(gen_running_i), .load_on_gen_i(load_on_gen_i),
		.silent_mode_i(silent_mode_i), .sys_fault_i(sys_fault_i), .maintained_i(1'b1),
		.gen_start_o(gen_start_o), .link(lk.xfer));

	rap_assertions i_rap_assertions (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
		.test_contact(lk.test_contact), .load_on_gen(lk.load_on_gen),
		.gen_running(lk.gen_running), .silent_mode(lk.silent_mode), .sys_fault(lk.sys_fault),
		.test_btn_i(test_btn_i), .silence_btn_i(silence_btn_i), .batt_low_i(batt_low_i),
		.utility_avail_i(utility_avail_i), .gen_start_o(gen_start_o),
		.run_lamp_o(run_lamp_o), .fault_lamp_o(fault_lamp_o), .chirp_o(chirp_o));

	// ==========================================================
	// helpers
	task automatic tk(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// counts rising edges of lamp 0 run, 1 fault, 2 sounder
	task automatic rises(input int w, input int n, output logic [7:0] c);
		logic p;
		logic s;
		s = (w == 0) ? run_lamp_o : (w == 1) ? fault_lamp_o : chirp_o;
		c = 8'h00;
		repeat (n) begin
			p = s;
			@(posedge sys_clk_i);
			s = (w == 0) ? run_lamp_o : (w == 1) ? fault_lamp_o : chirp_o;
			if (s && !p)
				c = c + 8'h01;
		end
	endtask

	// long enough for sync, debounce and hold even at worst tick phase
	task automatic hold_test();
		test_btn_i <= 1'b1;
		tk(60);
		test_btn_i <= 1'b0;
		tk(30);
	endtask

	task automatic press_silence();
		silence_btn_i <= 1'b1;
		tk(40);
		chk({run_lamp_o, fault_lamp_o}, 8'h03);
		silence_btn_i <= 1'b0;
		tk(30);
	endtask

	// ==========================================================
	// scenarios
	task automatic t_start_stop();
		logic [7:0] c;
		hold_test();
		chk(lk.test_contact, 8'h01);
		chk(gen_start_o, 8'h01);
		rises(0, 64, c);
		chk(c, 8'h02);
		gen_running_i <= 1'b1;
		load_on_gen_i <= 1'b1;
		tk(20);
		rises(0, 64, c);
		chk({c[6:0], run_lamp_o}, 8'h01);
		rises(2, 800, c);
		chk(c, 8'h01);
		hold_test();
		chk({lk.test_contact, gen_start_o}, 8'h00);
		rises(0, 64, c);
		chk(c, 8'h02);
		gen_running_i <= 1'b0;
		load_on_gen_i <= 1'b0;
		tk(20);
		chk(run_lamp_o, 8'h00);
		$display("t_start_stop done");
	endtask

	task automatic t_refused();
		utility_avail_i <= 1'b0;
		hold_test();
		gen_running_i <= 1'b1;
		load_on_gen_i <= 1'b1;
		tk(20);
		hold_test();
		chk({lk.test_contact, gen_start_o}, 8'h01);
		utility_avail_i <= 1'b1;
		tk(10);
		chk(gen_start_o, 8'h00);
		gen_running_i <= 1'b0;
		load_on_gen_i <= 1'b0;
		tk(20);
		$display("t_refused done");
	endtask

	task automatic t_auto_run();
		logic [7:0] c;
		gen_running_i <= 1'b1;
		load_on_gen_i <= 1'b1;
		tk(10);
		rises(2, 900, c);
		chk({c[6:0], run_lamp_o}, 8'h01);
		silent_mode_i <= 1'b1;
		tk(10);
		rises(0, 64, c);
		chk(c, 8'h04);
		chk(chirp_o, 8'h00);
		silent_mode_i <= 1'b0;
		gen_running_i <= 1'b0;
		load_on_gen_i <= 1'b0;
		tk(10);
		$display("t_auto_run done");
	endtask

	task automatic t_fault_silence();
		logic [7:0] c;
		sys_fault_i <= 1'b1;
		rises(2, 790, c);
		chk({c[6:0], fault_lamp_o}, 8'h07);
		press_silence();
		rises(2, 800, c);
		chk(c, 8'h00);
		press_silence();
		rises(2, 800, c);
		chk(c, 8'h03);
		sys_fault_i <= 1'b0;
		batt_low_i <= 1'b1;
		tk(10);
		chk(fault_lamp_o, 8'h01);
		batt_low_i <= 1'b0;
		tk(10);
		$display("t_fault_silence done");
	endtask

	task automatic t_battery();
		no_source_i <= 1'b1;
		hold_test();
		tk(60);
		chk(lk.test_contact, 8'h01);
		tk(150);
		chk(lk.test_contact, 8'h00);
		no_source_i <= 1'b0;
		tk(10);
		$display("t_battery done");
	endtask

	task automatic t_timeout();
		logic [7:0] c;
		hold_test();
		tk(260);
		rises(1, 64, c);
		chk(c, 8'h02);
		// a low enable must freeze the fault lamp blink on the panel
		ce_i <= 1'b0;
		tk(1);
		rises(1, 64, c);
		chk(c, 8'h00);
		ce_i <= 1'b1;
		hold_test();
		rises(1, 64, c);
		chk({c[6:0], lk.test_contact}, 8'h00);
		$display("t_timeout done");
	endtask

	// ==========================================================
	// run control
	task automatic test_done();
		$display("comparisons %0d, mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		sys_clk_i = 1'b0;
		forever #20 sys_clk_i = ~sys_clk_i;
	end

	initial begin
		repeat (20000) @(posedge sys_clk_i);
		n_errors++;
		test_done();
	end

	initial begin
		n_errors = 0;
		checks = 0;
		rst_b_i = 1'b0;
		{test_btn_i, silence_btn_i, batt_low_i, no_source_i} = 4'h0;
		{gen_running_i, load_on_gen_i, silent_mode_i, sys_fault_i} = 4'h0;
		utility_avail_i = 1'b1;
		ce_i = 1'b1;
		tk(5);
		rst_b_i <= 1'b1;
		tk(20);
		t_start_stop();
		t_refused();
		t_auto_run();
		t_fault_silence();
		t_battery();
		t_timeout();
		test_done();
	end
endmodule
